// *** hdl/ser_cfg_pkg.sv ***
// Purpose: Shared constants and types for the serializer configuration slave
// Assumes: 8-bit registers, 7-bit bus addresses
// Notes: Offsets, field positions, reset values and write masks live here
package ser_cfg_pkg;

  // Register offsets
  localparam logic [7:0] OFS_MAIN_CFG = 8'h00;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h01;
  localparam logic [7:0] OFS_EMPH = 8'h02;

  // Values after reset or power-down
  localparam logic [7:0] RST_MAIN_CFG = 8'h00;
  localparam logic [7:0] RST_BUS_ADDR = 8'h68;
  localparam logic [7:0] RST_EMPH = 8'h00;

  // Writable bits; reserved bits without write access read zero
  localparam logic [7:0] WMASK_MAIN_CFG = 8'hEF;
  localparam logic [7:0] WMASK_BUS_ADDR = 8'hFF;
  localparam logic [7:0] WMASK_EMPH = 8'hF0;

  // Main configuration fields
  localparam int CFG_SRC_BIT = 0;
  localparam int SLEEP_BIT = 1;
  localparam int FILTER_LSB = 2;
  localparam int SWING_BIT = 5;
  localparam int LANE_BIT = 6;
  localparam logic [1:0] FILTER_ON = 2'h1;

  // Bus address control fields
  localparam int ADDR_SRC_BIT = 7;

  // Emphasis control fields
  localparam int EMPH_DIS_BIT = 4;
  localparam int EMPH_LSB = 5;
  localparam logic [2:0] EMPH_EXTERNAL = 3'h0;

  // Strap-decoded addresses
  localparam logic [6:0] STRAP_ADDR_0 = 7'h69;
  localparam logic [6:0] STRAP_ADDR_1 = 7'h6A;
  localparam logic [6:0] STRAP_ADDR_2 = 7'h6B;
  localparam logic [6:0] STRAP_ADDR_3 = 7'h6E;

  // Bits per byte on the bus
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Bus protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK
  } bus_state_e;

endpackage : ser_cfg_pkg

// *** hdl/sync_if.sv ***
// Purpose: Carries a synchronised level and its edges between modules
// Assumes: Edges are one-cycle pulses in the clk domain
// Notes: Width set per instance
`timescale 1ns/1ns
interface sync_if #(parameter int W = 1);
  logic [W-1:0] level; // Filtered level
  logic [W-1:0] rise; // Level goes high next cycle
  logic [W-1:0] fall; // Level goes low next cycle
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sync_if

// *** hdl/pin_sync.sv ***
// Purpose: Three-flop synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: Level changes only once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin,
  sync_if.src out
);

  logic [W-1:0] ff1_r, ff2_r, ff3_r, level_r; // Chain and filtered level
  logic [W-1:0] ff1_nxt, ff2_nxt, ff3_nxt, level_nxt; // Next values

  // Next values: shift chain, level follows when stages agree
  always_comb begin
    ff1_nxt = pin;
    ff2_nxt = ff1_r;
    ff3_nxt = ff2_r;
    level_nxt = (ff2_r & ff3_r) | (level_r & (ff2_r | ff3_r));
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      ff1_r <= ff1_nxt;
      ff2_r <= ff2_nxt;
      ff3_r <= ff3_nxt;
      level_r <= level_nxt;
    end
  end

  // Filtered level and edge pulses
  assign out.level = level_r;
  assign out.rise = ~level_r & ff2_r & ff3_r;
  assign out.fall = level_r & ~ff2_r & ~ff3_r;

endmodule : pin_sync

// *** hdl/serializer_config_bus_slave.sv ***
// Purpose: Two-wire configuration bus slave with register bank for a link serializer
// Assumes: clk 100 MHz; bus clock from master, oversampled; no clock stretching
// Notes: Open-drain SDA as in/out/oe; sda_oe high pulls the line low
// Operation
// - Source register resets zero; 0x01 selects registers
// - Strap picks one of four addresses
// - Detect start and stop framing on bus
// - Acknowledge matching address, release on mismatch
// - Acknowledge every written data byte
// - Lines only released or driven low
// - Bit 6 selects input lane ordering
// - Bits 3:2 control the control-signal filter
// - Bit 1 sleeps, registers kept
// - Bit 0 selects pins or registers
// - Address register bit 7 selects address source
// - Register address should be a documented one
// - Emphasis bits 7:5 select level
// - Emphasis bit 4 set disables emphasis
// - Power-down input resets all registers
`timescale 1ns/1ns
module serializer_config_bus_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] address_strap,
  input wire logic pin_lane_order,
  input wire logic pin_swing_level,
  input wire logic pin_filter_enable,
  output logic config_from_regs,
  output logic lane_order_select,
  output logic swing_level_select,
  output logic filter_enable,
  output logic sleep_mode,
  output logic [2:0] emphasis_level,
  output logic emphasis_disable,
  output logic [6:0] own_address
);

  // Synchronised pins
  sync_if #(.W(2)) bus_s (); // Bit 1 scl, bit 0 sda
  sync_if #(.W(1)) pdn_s (); // Power-down, low active
  sync_if #(.W(5)) strap_s (); // Straps and pin settings

  pin_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin({scl_in, sda_in}),
    .out(bus_s)
  );

  pin_sync #(.W(1), .RST_VAL(1'h1)) u_pdn_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(power_down_n),
    .out(pdn_s)
  );

  pin_sync #(.W(5), .RST_VAL(5'h00)) u_strap_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin({address_strap, pin_lane_order, pin_swing_level, pin_filter_enable}),
    .out(strap_s)
  );

  // Bus events
  logic scl_high; // Clock line high
  logic scl_rise; // Clock rising edge
  logic scl_fall; // Clock falling edge
  logic start_det; // Start or repeated start
  logic stop_det; // Stop
  logic clr_all; // Reset or power-down

  assign scl_high = bus_s.level[1];
  assign scl_rise = bus_s.rise[1];
  assign scl_fall = bus_s.fall[1];
  assign start_det = bus_s.fall[0] & scl_high;
  assign stop_det = bus_s.rise[0] & scl_high;
  assign clr_all = sys_rst | ~pdn_s.level[0];

  // Register bank
  logic [7:0] main_cfg_r, main_cfg_nxt; // Main configuration
  logic [7:0] bus_addr_r, bus_addr_nxt; // Bus address control
  logic [7:0] emph_r, emph_nxt; // Emphasis control

  // Protocol state
  ser_cfg_pkg::bus_state_e state_r, state_nxt; // Bus state
  logic [3:0] bit_cnt_r, bit_cnt_nxt; // Bits in current byte
  logic [7:0] shift_r, shift_nxt; // Received byte
  logic [7:0] tx_r, tx_nxt; // Byte being sent
  logic [7:0] ptr_r, ptr_nxt; // Register pointer
  logic rw_r, rw_nxt; // Read requested
  logic mack_r, mack_nxt; // Master acknowledged
  logic oe_r, oe_nxt; // Pull SDA low

  // Address decode
  logic [6:0] strap_addr; // Strap-decoded address
  logic [7:0] rd_data; // Register at pointer

  // Strap decode, four shareable addresses
  always_comb begin
    unique case (strap_s.level[4:3])
      2'h0: strap_addr = ser_cfg_pkg::STRAP_ADDR_0;
      2'h1: strap_addr = ser_cfg_pkg::STRAP_ADDR_1;
      2'h2: strap_addr = ser_cfg_pkg::STRAP_ADDR_2;
      2'h3: strap_addr = ser_cfg_pkg::STRAP_ADDR_3;
    endcase
  end

  // Address source; reserved register values used as written
  logic [6:0] addr_sel; // Active address
  assign addr_sel = bus_addr_r[ser_cfg_pkg::ADDR_SRC_BIT] ? bus_addr_r[6:0]
                  : strap_addr;

  // Read mux, unmapped offsets read zero
  always_comb begin
    unique case (ptr_r)
      ser_cfg_pkg::OFS_MAIN_CFG: rd_data = main_cfg_r;
      ser_cfg_pkg::OFS_BUS_ADDR: rd_data = bus_addr_r;
      ser_cfg_pkg::OFS_EMPH: rd_data = emph_r;
      default: rd_data = 8'h00;
    endcase
  end

  // Protocol and register next values
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    oe_nxt = oe_r;
    main_cfg_nxt = main_cfg_r;
    bus_addr_nxt = bus_addr_r;
    emph_nxt = emph_r;
    if (start_det) begin
      // Start or repeated start: expect address, pointer kept
      state_nxt = ser_cfg_pkg::ST_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_det) begin
      // Stop ends any transfer
      state_nxt = ser_cfg_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      // Sample on rising clock
      unique case (state_r)
        ser_cfg_pkg::ST_ADDR, ser_cfg_pkg::ST_PTR, ser_cfg_pkg::ST_WDATA: begin
          shift_nxt = {shift_r[6:0], bus_s.level[0]};
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        ser_cfg_pkg::ST_RDATA: begin
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        ser_cfg_pkg::ST_RACK: begin
          mack_nxt = ~bus_s.level[0];
        end
        default: begin
          // Idle and slave ack slots sample nothing
        end
      endcase
    end else if (scl_fall) begin
      // Change SDA on falling clock
      unique case (state_r)
        ser_cfg_pkg::ST_ADDR: begin
          if (bit_cnt_r == ser_cfg_pkg::BYTE_BITS) begin
            if (shift_r[7:1] == addr_sel) begin
              oe_nxt = 1'b1;
              rw_nxt = shift_r[0];
              state_nxt = ser_cfg_pkg::ST_ADDR_ACK;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = ser_cfg_pkg::ST_IDLE;
            end
          end
        end
        ser_cfg_pkg::ST_ADDR_ACK: begin
          bit_cnt_nxt = 4'h0;
          if (rw_r) begin
            // Read from pointer, first bit out now
            tx_nxt = rd_data;
            oe_nxt = ~rd_data[7];
            ptr_nxt = ptr_r + 8'h01;
            state_nxt = ser_cfg_pkg::ST_RDATA;
          end else begin
            oe_nxt = 1'b0;
            state_nxt = ser_cfg_pkg::ST_PTR;
          end
        end
        ser_cfg_pkg::ST_PTR: begin
          if (bit_cnt_r == ser_cfg_pkg::BYTE_BITS) begin
            ptr_nxt = shift_r;
            oe_nxt = 1'b1;
            state_nxt = ser_cfg_pkg::ST_PTR_ACK;
          end
        end
        ser_cfg_pkg::ST_PTR_ACK, ser_cfg_pkg::ST_WDATA_ACK: begin
          oe_nxt = 1'b0;
          bit_cnt_nxt = 4'h0;
          state_nxt = ser_cfg_pkg::ST_WDATA;
        end
        ser_cfg_pkg::ST_WDATA: begin
          if (bit_cnt_r == ser_cfg_pkg::BYTE_BITS) begin
            // Commit byte, writable bits only
            unique case (ptr_r)
              ser_cfg_pkg::OFS_MAIN_CFG:
                main_cfg_nxt = shift_r & ser_cfg_pkg::WMASK_MAIN_CFG;
              ser_cfg_pkg::OFS_BUS_ADDR:
                bus_addr_nxt = shift_r & ser_cfg_pkg::WMASK_BUS_ADDR;
              ser_cfg_pkg::OFS_EMPH:
                emph_nxt = shift_r & ser_cfg_pkg::WMASK_EMPH;
              default: begin
                // Unmapped offset, byte dropped but acknowledged
              end
            endcase
            ptr_nxt = ptr_r + 8'h01;
            oe_nxt = 1'b1;
            state_nxt = ser_cfg_pkg::ST_WDATA_ACK;
          end
        end
        ser_cfg_pkg::ST_RDATA: begin
          if (bit_cnt_r == ser_cfg_pkg::BYTE_BITS) begin
            // Release for the master's ack bit
            oe_nxt = 1'b0;
            state_nxt = ser_cfg_pkg::ST_RACK;
          end else begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = ~tx_r[6];
          end
        end
        ser_cfg_pkg::ST_RACK: begin
          if (mack_r) begin
            // Master wants another byte
            tx_nxt = rd_data;
            oe_nxt = ~rd_data[7];
            ptr_nxt = ptr_r + 8'h01;
            bit_cnt_nxt = 4'h0;
            state_nxt = ser_cfg_pkg::ST_RDATA;
          end else begin
            // Nack: wait for stop
            oe_nxt = 1'b0;
            state_nxt = ser_cfg_pkg::ST_IDLE;
          end
        end
        default: begin
          // Idle ignores clock edges
        end
      endcase
    end
  end

  // Protocol and register flops; power-down clears, sleep keeps
  always_ff @(posedge clk) begin
    if (clr_all) begin
      state_r <= ser_cfg_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      main_cfg_r <= ser_cfg_pkg::RST_MAIN_CFG;
      bus_addr_r <= ser_cfg_pkg::RST_BUS_ADDR;
      emph_r <= ser_cfg_pkg::RST_EMPH;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
      oe_r <= oe_nxt;
      main_cfg_r <= main_cfg_nxt;
      bus_addr_r <= bus_addr_nxt;
      emph_r <= emph_nxt;
    end
  end

  // Effective configuration outputs
  logic src_r, src_nxt; // Registers in control
  logic lane_r, lane_nxt; // Lane ordering
  logic swing_r, swing_nxt; // Output swing
  logic filt_r, filt_nxt; // Control filter
  logic sleep_r, sleep_nxt; // Sleep
  logic [2:0] emph_lvl_r, emph_lvl_nxt; // Emphasis level
  logic emph_dis_r, emph_dis_nxt; // Emphasis off

  // Pin or register source for lane, swing and filter; emphasis fixed to external in pin mode; sleep always from its register bit
  always_comb begin
    src_nxt = main_cfg_r[ser_cfg_pkg::CFG_SRC_BIT];
    sleep_nxt = main_cfg_r[ser_cfg_pkg::SLEEP_BIT];
    if (src_nxt) begin
      lane_nxt = main_cfg_r[ser_cfg_pkg::LANE_BIT];
      swing_nxt = main_cfg_r[ser_cfg_pkg::SWING_BIT];
      // Reserved filter codes leave the filter off
      filt_nxt = main_cfg_r[ser_cfg_pkg::FILTER_LSB +: 2] == ser_cfg_pkg::FILTER_ON;
      emph_lvl_nxt = emph_r[ser_cfg_pkg::EMPH_LSB +: 3];
      emph_dis_nxt = emph_r[ser_cfg_pkg::EMPH_DIS_BIT];
    end else begin
      lane_nxt = strap_s.level[2];
      swing_nxt = strap_s.level[1];
      filt_nxt = strap_s.level[0];
      emph_lvl_nxt = ser_cfg_pkg::EMPH_EXTERNAL;
      emph_dis_nxt = 1'b0;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (clr_all) begin
      src_r <= 1'b0;
      lane_r <= 1'b0;
      swing_r <= 1'b0;
      filt_r <= 1'b0;
      sleep_r <= 1'b0;
      emph_lvl_r <= 3'h0;
      emph_dis_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      lane_r <= lane_nxt;
      swing_r <= swing_nxt;
      filt_r <= filt_nxt;
      sleep_r <= sleep_nxt;
      emph_lvl_r <= emph_lvl_nxt;
      emph_dis_r <= emph_dis_nxt;
    end
  end

  // Open drain: never drive high
  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign config_from_regs = src_r;
  assign lane_order_select = lane_r;
  assign swing_level_select = swing_r;
  assign filter_enable = filt_r;
  assign sleep_mode = sleep_r;
  assign emphasis_level = emph_lvl_r;
  assign emphasis_disable = emph_dis_r;
  assign own_address = addr_sel;

endmodule : serializer_config_bus_slave

// *** verification/serializer_config_bus_slave_asserts.sv ***
// Purpose: Port-level checker for the configuration bus slave
// Assumes: Single clk domain; sys_rst synchronous; pins synced in 3-4 clk
// Notes: Bound from the testbench top file
`timescale 1ns/1ns
module serializer_config_bus_slave_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] address_strap,
  input wire logic pin_lane_order,
  input wire logic pin_swing_level,
  input wire logic pin_filter_enable,
  input wire logic config_from_regs,
  input wire logic lane_order_select,
  input wire logic swing_level_select,
  input wire logic filter_enable,
  input wire logic sleep_mode,
  input wire logic [2:0] emphasis_level,
  input wire logic emphasis_disable,
  input wire logic [6:0] own_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Strap code to bus address
  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    case (s)
      2'h0: strap_addr = 7'h69;
      2'h1: strap_addr = 7'h6A;
      2'h2: strap_addr = 7'h6B;
      default: strap_addr = 7'h6E;
    endcase
  endfunction : strap_addr

  // Bus clock held high long enough to be synced
  sequence scl_steady;
    scl_in [*5];
  endsequence
  // Long reset followed by a quiet run
  sequence rst_run;
    sys_rst [*8] ##1 !sys_rst [*5];
  endsequence
  // A pin holds its level in pin mode
  sequence pin_quiet(p);
    (!config_from_regs && $stable(p)) [*5];
  endsequence

  a_sda_out_zero: assert property (sda_out == 1'b0)
    else $error("data output value not low");
  a_oe_frozen_high: assert property (scl_steady |=> $stable(sda_oe))
    else $error("data line changed while bus clock high");
  a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
    else $error("data line drive changed too soon after clock fall");
  a_strap_after_rst: assert property (disable iff (!power_down_n)
    rst_run |-> own_address == strap_addr(address_strap))
    else $error("own address differs from strap decode");
  a_reset_clears: assert property ($fell(sys_rst) |->
    !sda_oe && !config_from_regs && !sleep_mode)
    else $error("state not cleared by reset");
  a_pd_clears: assert property (!power_down_n [*6] |-> !config_from_regs && !sleep_mode
    && emphasis_level == 3'h0 && !emphasis_disable && !sda_oe)
    else $error("power-down did not clear settings");
  a_emph_pin_mode: assert property (!config_from_regs |->
    emphasis_level == 3'h0 && !emphasis_disable)
    else $error("emphasis not external in pin mode");
  // Output lags the pin; compare with the settled value, still in pin mode
  a_lane_pin_mode: assert property (pin_quiet(pin_lane_order) ##1 !config_from_regs |->
    lane_order_select == $past(pin_lane_order))
    else $error("lane order not from pin");
  a_swing_pin_mode: assert property (pin_quiet(pin_swing_level) ##1 !config_from_regs |->
    swing_level_select == $past(pin_swing_level))
    else $error("swing level not from pin");
  a_filter_pin_mode: assert property (pin_quiet(pin_filter_enable) ##1 !config_from_regs |->
    filter_enable == $past(pin_filter_enable))
    else $error("filter not from pin");
endmodule : serializer_config_bus_slave_asserts

// *** verification/cfg_bus_master.sv ***
// Purpose: Behavioural two-wire bus master driving the slave
// Assumes: Pulled-up data line; 160 ns bus clock period
// Notes: Steps on clk falling edges; bus clock stands high when idle
`timescale 1ns/1ns
module cfg_bus_master (
  input wire logic clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda_oe
);
  logic line; // Wired level: released master and slave give high
  assign line = sda_drv & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Quarter bus clock period
  task automatic q;
    repeat (4) @(negedge clk);
  endtask : q
  // Start or repeated start: data falls with clock high
  task automatic start;
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : start
  // Stop: data rises with clock high
  task automatic stop;
    sda_drv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
  endtask : stop
  // One bit, data changed only while clock low
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    q();
    scl = 1'b1;
    q();
    r = line;
    q();
    scl = 1'b0;
    q();
  endtask : bit_x
  // Send a byte, MSB first, and return the acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // Receive a byte; ack for more, nack on the last
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~more, r);
  endtask : rbyte
endmodule : cfg_bus_master

// *** verification/test_serializer_config_bus_slave.sv ***
// Purpose: Self-checking bench for the configuration bus slave
// Assumes: 100 MHz clk; bus master model on the far side
// Notes: Register model kept in ints, compared at every result
`timescale 1ns/1ns
module test_serializer_config_bus_slave;
  logic clk = 1'b0; // System clock
  logic sys_rst = 1'b1; // Sync reset
  logic power_down_n = 1'b1; // Power-down pin
  logic [1:0] address_strap = 2'h0; // Address strap
  logic [2:0] pins = 3'h0; // Lane, swing, filter pins
  logic scl, sda_drv, sda_out, sda_oe, cfg, lane, swing, filt, slp, edis, ack;
  logic [2:0] elev;
  logic [6:0] own, dev;
  logic [7:0] a, c;
  logic [6:0] tab [4] = '{7'h69, 7'h6A, 7'h6B, 7'h6E}; // Strap addresses
  int mdl [3]; // Register model
  int error_cnt = 0;
  int total_checks = 0;
  always #5 clk = ~clk;

  cfg_bus_master mst (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_oe(sda_oe));
  serializer_config_bus_slave uut (.clk(clk), .sys_rst(sys_rst), .power_down_n(power_down_n),
    .scl_in(scl), .sda_in(sda_drv & ~sda_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap(address_strap), .pin_lane_order(pins[0]), .pin_swing_level(pins[1]),
    .pin_filter_enable(pins[2]), .config_from_regs(cfg), .lane_order_select(lane),
    .swing_level_select(swing), .filter_enable(filt), .sleep_mode(slp),
    .emphasis_level(elev), .emphasis_disable(edis), .own_address(own));

  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Verdict and end of run
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Pointer then data bytes; model keeps writable bits only
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    int m [3] = '{ser_cfg_pkg::WMASK_MAIN_CFG, ser_cfg_pkg::WMASK_BUS_ADDR,
      ser_cfg_pkg::WMASK_EMPH};
    mst.start();
    mst.wbyte({dev, 1'b0}, ack);
    chk("addr ack", 8'h01, ack);
    mst.wbyte(p, ack);
    chk("ptr ack", 8'h01, ack);
    foreach (d[i]) begin
      mst.wbyte(d[i], ack);
      chk("data ack", 8'h01, ack);
      if (p < 3) mdl[p] = d[i] & m[p];
      p++;
    end
    mst.stop();
  endtask : wr
  // Pointer, repeated start, n bytes
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] rb;
    mst.start();
    mst.wbyte({dev, 1'b0}, ack);
    mst.wbyte(p, ack);
    mst.start();
    mst.wbyte({dev, 1'b1}, ack);
    chk("read ack", 8'h01, ack);
    for (int i = 0; i < n; i++) begin
      mst.rbyte(i < n - 1, rb);
      chk("read data", (p < 3) ? mdl[p][7:0] : 8'h00, rb);
      p++;
    end
    mst.stop();
  endtask : rd
  // Settings outputs against model and pins
  task automatic outs;
    logic r;
    repeat (8) @(negedge clk);
    r = mdl[0][0];
    chk("cfg", r, cfg);
    chk("lane", r ? mdl[0][6] : pins[0], lane);
    chk("swing", r ? mdl[0][5] : pins[1], swing);
    chk("filter", r ? (mdl[0][3:2] == 1) : pins[2], filt);
    chk("sleep", mdl[0][1], slp);
    chk("emph", r ? mdl[2][7:5] : 3'h0, elev);
    chk("edis", r ? mdl[2][4] : 1'b0, edis);
    chk("own", mdl[1][7] ? mdl[1][6:0] : tab[address_strap], own);
  endtask : outs

  // Main sequence
  initial begin
    void'($urandom(49));
    mdl = '{8'h00, 8'h68, 8'h00};
    dev = 7'h69;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    rd(0, 3);
    outs();
    // Each strap code, then a foreign address
    for (int s = 0; s < 4; s++) begin
      address_strap = s[1:0];
      dev = tab[s];
      outs();
      rd(1, 1);
      mst.start();
      mst.wbyte({dev ^ 7'h01, 1'b0}, ack);
      chk("foreign nack", 8'h00, ack);
      mst.stop();
    end
    address_strap = 2'h0;
    dev = 7'h69;
    wr(0, {8'h01});
    outs();
    // Pin mode first half, register mode second: every filter and emphasis code
    for (int i = 0; i < 16; i++) begin
      pins = 3'($urandom);
      a = 8'($urandom);
      c = 8'($urandom);
      a[3:2] = i[1:0];
      a[0] = i[3];
      c[7:5] = i[2:0];
      wr(0, {a, 8'h68, c});
      outs();
      rd(0, 3);
    end
    // Unmapped offset: accepted, dropped, reads zero
    wr(3, {8'hA5});
    rd(3, 1);
    // Register-held address
    wr(1, {8'hEB});
    dev = 7'h6B;
    outs();
    rd(0, 3);
    // Power-down restores defaults
    pins = 3'h0;
    power_down_n = 1'b0;
    repeat (10) @(negedge clk);
    power_down_n = 1'b1;
    repeat (8) @(negedge clk);
    mdl = '{8'h00, 8'h68, 8'h00};
    dev = 7'h69;
    outs();
    rd(0, 3);
    finish_test();
  end

  // Watchdog against a hung bus
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule : test_serializer_config_bus_slave

bind serializer_config_bus_slave serializer_config_bus_slave_asserts chk_i (.clk(clk),
  .sys_rst(sys_rst), .power_down_n(power_down_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .address_strap(address_strap), .pin_lane_order(pin_lane_order),
  .pin_swing_level(pin_swing_level), .pin_filter_enable(pin_filter_enable),
  .config_from_regs(config_from_regs), .lane_order_select(lane_order_select),
  .swing_level_select(swing_level_select), .filter_enable(filter_enable),
  .sleep_mode(sleep_mode), .emphasis_level(emphasis_level),
  .emphasis_disable(emphasis_disable), .own_address(own_address));
